/* logic/cprc_page_run.sv */
// Function
// - Eight-bit selector; 0x00-0x07 steer paged commands to one channel.
// - Broadcast selector accepts only run-control and on/off configuration writes.
// - Broadcast writes update only channels enabled in the global-write mask.
// - Paged read under broadcast selector returns junk and sets comm fault.
// - Run byte fields: run 7:6, margin 5:4, fault 3:2; 1:0 read zero.
// - Channel on/off comes from run field, run pin and on/off configuration.
// - Bus control on: run 00 off now, 10 on, 01 sequenced off.
// - Margin field: 00 nominal, 01 low, 10 high; nominal ignores fault field.
// - While margining, fault field 01 suppresses faults, 10 honours them.
// - Run 01 with nominal margin starts sequenced off at nominal target.
// - Run 01 with low/high margin sequences off and applies margin and policy.
// - Bus control off: run field 00/01/10 ignored; margin 00 keeps nominal.
// - Bus control off: margin low/high and fault policy still apply.
// - Configuration bit 3 decides whether the run field is obeyed.
// - Global-write mask per channel, resets to all eight enabled.
`timescale 1ns/100ps
`include "cprc_regs.svh"

module cprc_page_run (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire cprc_pkg::cprc_cmd_type cmd,
    output logic rd_valid,
    output logic [7:0] rd_data,
    input wire logic cml_clear,
    output logic cml_fault,
    input wire logic [7:0] channel_run_pin,
    output logic [7:0] chan_enable,
    output logic [7:0] fast_off,
    output logic [7:0] off_now,
    output logic [7:0] seq_off,
    output logic [7:0] margin_low,
    output logic [7:0] margin_high,
    output logic [7:0] fault_suppress
);

    // Legal run byte for a channel, given its bus-control bit
    function automatic logic oper_legal(input logic [7:0] b, input logic use_bus);
        cprc_pkg::cprc_oper_type o;
        logic margin_ok;
        o = cprc_pkg::cprc_oper_type'(b);
        margin_ok = (o.margin == cprc_pkg::CPRC_MARGIN_NOM) ||
                    ((o.margin != cprc_pkg::CPRC_MARGIN_RSVD) &&
                     ((o.fault == cprc_pkg::CPRC_FAULT_IGNORE) ||
                      (o.fault == cprc_pkg::CPRC_FAULT_HONOUR)));
        if (o.run == cprc_pkg::CPRC_RUN_RSVD) begin
            oper_legal = 1'b0;
        end else if (use_bus && (o.run == cprc_pkg::CPRC_RUN_OFF)) begin
            oper_legal = 1'b1;
        end else begin
            oper_legal = margin_ok;
        end
    endfunction

    logic [7:0] page;
    logic [7:0] gw_mask;
    logic [7:0] local_q;
    logic rd_paged;
    logic [7:0] pin_s1, pin_s2, pin_s3, pin_level;
    logic [7:0] store_q;
    logic [63:0] oper_all, cfg_all;

    // Selector and command decode
    wire page_is_chan = (page <= `CPRC_PAGE_LAST);
    wire page_is_all = (page == `CPRC_PAGE_ALL);
    wire is_page = (cmd.code == `CPRC_CMD_PAGE);
    wire is_mask = (cmd.code == `CPRC_CMD_PAGE_MASK);
    wire is_oper = (cmd.code == `CPRC_CMD_OPERATION);
    wire is_cfg = (cmd.code == `CPRC_CMD_ON_OFF_CONFIG);
    wire is_paged = is_oper | is_cfg;
    wire new_page_ok = (cmd.data <= `CPRC_PAGE_LAST) || (cmd.data == `CPRC_PAGE_ALL);
    wire [7:0] one_chan = 8'h01 << page[2:0];
    wire [7:0] target = page_is_all ? gw_mask :
                        (page_is_chan ? one_chan : 8'h00);

    // Per-channel legality of the incoming run byte
    logic [7:0] oper_ok;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            oper_ok[i] = oper_legal(cmd.data, cfg_all[i*8 + `CPRC_CFG_USE_BUS]);
        end
    end

    wire wr_oper = cmd_wr & is_oper;
    wire wr_cfg = cmd_wr & is_cfg;
    wire oper_all_ok = &(oper_ok | ~target);
    wire [7:0] oper_we = (wr_oper & oper_all_ok) ? target : 8'h00;
    wire [7:0] cfg_we = wr_cfg ? target : 8'h00;

    // Communication fault causes
    wire bad_page_wr = cmd_wr & is_page & ~new_page_ok;
    wire bad_paged_wr = (wr_oper | wr_cfg) & ~page_is_chan & ~page_is_all;
    wire bad_oper_wr = wr_oper & ~oper_all_ok;
    wire bad_paged_rd = cmd_rd & is_paged & ~page_is_chan;
    wire cml_set = bad_page_wr | bad_paged_wr | bad_oper_wr | bad_paged_rd;

    // Selector, mask and fault flag; a new fault beats a clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            page <= `CPRC_PAGE_RESET;
            gw_mask <= `CPRC_MASK_RESET;
            cml_fault <= 1'b0;
        end else begin
            if (cmd_wr && is_page && new_page_ok) begin
                page <= cmd.data;
            end
            if (cmd_wr && is_mask) begin
                gw_mask <= cmd.data;
            end
            cml_fault <= cml_set | (cml_fault & ~cml_clear);
        end
    end

    // Read path; paged bytes come from the store, others from here
    // Source select and local byte only move on a read, so the answer holds
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid <= 1'b0;
            rd_paged <= 1'b0;
            local_q <= 8'h00;
        end else begin
            rd_valid <= cmd_rd & (is_page | is_mask | is_paged);
            if (cmd_rd) begin
                rd_paged <= is_paged;
                local_q <= is_page ? page : gw_mask;
            end
        end
    end
    assign rd_data = rd_paged ? store_q : local_q;

    cprc_chan_store u_store (
        .clk(clk),
        .rst_b(rst_b),
        .oper_we(oper_we),
        .cfg_we(cfg_we),
        .wdata(cmd.data),
        .rd_en(cmd_rd & is_paged),
        .rd_cfg(is_cfg),
        .rd_idx(page[2:0]),
        .rd_data(store_q),
        .oper_all(oper_all),
        .cfg_all(cfg_all)
    );

    // Run pins: three stages, a change counts when stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1 <= 8'h00;
            pin_s2 <= 8'h00;
            pin_s3 <= 8'h00;
            pin_level <= 8'h00;
        end else begin
            pin_s1 <= channel_run_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_level <= (pin_s2 & pin_s3) | (pin_level & (pin_s2 ^ pin_s3));
        end
    end

    // Per-channel run, margin and fault-policy decode
    logic [7:0] next_enable, next_off_now, next_seq_off;
    logic [7:0] next_low, next_high, next_suppress, next_fast;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            cprc_pkg::cprc_oper_type o;
            cprc_pkg::cprc_oper_type w;
            logic use_bus, use_pin, hold_nom, want;
            o = cprc_pkg::cprc_oper_type'(oper_all[i*8 +: 8]);
            w = cprc_pkg::cprc_oper_type'(cmd.data);
            use_bus = cfg_all[i*8 + `CPRC_CFG_USE_BUS];
            use_pin = cfg_all[i*8 + `CPRC_CFG_USE_PIN];
            // Bus-off immediate shutdown drops margin to nominal
            hold_nom = use_bus && (o.run == cprc_pkg::CPRC_RUN_OFF);
            want = (use_bus | use_pin) &
                   (~use_bus | (o.run == cprc_pkg::CPRC_RUN_ON)) &
                   (~use_pin | pin_level[i]);
            next_enable[i] = ~cfg_all[i*8 + `CPRC_CFG_CTRL_ON] | want;
            next_fast[i] = cfg_all[i*8 + `CPRC_CFG_FAST_OFF];
            next_off_now[i] = oper_we[i] & use_bus &
                              (w.run == cprc_pkg::CPRC_RUN_OFF);
            next_seq_off[i] = oper_we[i] & use_bus &
                              (w.run == cprc_pkg::CPRC_RUN_SEQ_OFF);
            next_low[i] = ~hold_nom & (o.margin == cprc_pkg::CPRC_MARGIN_LOW);
            next_high[i] = ~hold_nom & (o.margin == cprc_pkg::CPRC_MARGIN_HIGH);
            next_suppress[i] = (next_low[i] | next_high[i]) &
                               (o.fault == cprc_pkg::CPRC_FAULT_IGNORE);
        end
    end

    // Registered channel outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chan_enable <= 8'h00;
            fast_off <= 8'h00;
            off_now <= 8'h00;
            seq_off <= 8'h00;
            margin_low <= 8'h00;
            margin_high <= 8'h00;
            fault_suppress <= 8'h00;
        end else begin
            chan_enable <= next_enable;
            fast_off <= next_fast;
            off_now <= next_off_now;
            seq_off <= next_seq_off;
            margin_low <= next_low;
            margin_high <= next_high;
            fault_suppress <= next_suppress;
        end
    end

endmodule

/* logic/cprc_regs.svh */
`ifndef CPRC_REGS_SVH
`define CPRC_REGS_SVH

// Command codes seen on the decoded serial command port
`define CPRC_CMD_PAGE 8'h00
`define CPRC_CMD_OPERATION 8'h01
`define CPRC_CMD_ON_OFF_CONFIG 8'h02
`define CPRC_CMD_PAGE_MASK 8'he4

// Channel selector codes
`define CPRC_PAGE_LAST 8'h07
`define CPRC_PAGE_ALL 8'hff

// Reset values
`define CPRC_PAGE_RESET 8'h00
`define CPRC_MASK_RESET 8'hff
`define CPRC_OPER_RESET 8'h00
`define CPRC_CFG_RESET 8'h1e

// Run-control byte: writable bits, low two bits read as zero
`define CPRC_OPER_WMASK 8'hfc

// On/off configuration fields
`define CPRC_CFG_CTRL_ON 4
`define CPRC_CFG_USE_BUS 3
`define CPRC_CFG_USE_PIN 2
`define CPRC_CFG_FAST_OFF 0
`define CPRC_CFG_WMASK 8'h1d
`define CPRC_CFG_ONES 8'h02

`endif

/* logic/cprc_pkg.sv */
package cprc_pkg;

    typedef enum logic [1:0] {
        CPRC_RUN_OFF = 2'h0,
        CPRC_RUN_SEQ_OFF = 2'h1,
        CPRC_RUN_ON = 2'h2,
        CPRC_RUN_RSVD = 2'h3
    } cprc_run_type;

    typedef enum logic [1:0] {
        CPRC_MARGIN_NOM = 2'h0,
        CPRC_MARGIN_LOW = 2'h1,
        CPRC_MARGIN_HIGH = 2'h2,
        CPRC_MARGIN_RSVD = 2'h3
    } cprc_margin_type;

    typedef enum logic [1:0] {
        CPRC_FAULT_RSVD0 = 2'h0,
        CPRC_FAULT_IGNORE = 2'h1,
        CPRC_FAULT_HONOUR = 2'h2,
        CPRC_FAULT_RSVD3 = 2'h3
    } cprc_fault_type;

    // Run-control byte layout, bit 7 first
    typedef struct packed {
        cprc_run_type run;
        cprc_margin_type margin;
        cprc_fault_type fault;
        logic [1:0] rsvd;
    } cprc_oper_type;

    // One decoded command from the serial engine
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] data;
    } cprc_cmd_type;

endpackage

/* logic/cprc_chan_store.sv */
`timescale 1ns/100ps
`include "cprc_regs.svh"

module cprc_chan_store (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] oper_we,
    input wire logic [7:0] cfg_we,
    input wire logic [7:0] wdata,
    input wire logic rd_en,
    input wire logic rd_cfg,
    input wire logic [2:0] rd_idx,
    output logic [7:0] rd_data,
    output logic [63:0] oper_all,
    output logic [63:0] cfg_all
);

    logic [7:0] oper_mem [8];
    logic [7:0] cfg_mem [8];

    // Masked per-channel writes; unselected channels keep their bytes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 8; i++) begin
                oper_mem[i] <= `CPRC_OPER_RESET;
                cfg_mem[i] <= `CPRC_CFG_RESET;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (oper_we[i]) begin
                    oper_mem[i] <= wdata & `CPRC_OPER_WMASK;
                end
                if (cfg_we[i]) begin
                    cfg_mem[i] <= (wdata & `CPRC_CFG_WMASK) | `CPRC_CFG_ONES;
                end
            end
        end
    end

    // Registered read port
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= rd_cfg ? cfg_mem[rd_idx] : oper_mem[rd_idx];
        end
    end

    // Flat view for the run decoders
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            oper_all[i*8 +: 8] = oper_mem[i];
            cfg_all[i*8 +: 8] = cfg_mem[i];
        end
    end

endmodule

/* tb/cprc_page_run_properties.sv */
`timescale 1ns/100ps
`include "cprc_regs.svh"

module cprc_page_run_properties (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire cprc_pkg::cprc_cmd_type cmd,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic cml_clear,
    input wire logic cml_fault,
    input wire logic [7:0] channel_run_pin,
    input wire logic [7:0] chan_enable,
    input wire logic [7:0] fast_off,
    input wire logic [7:0] off_now,
    input wire logic [7:0] seq_off,
    input wire logic [7:0] margin_low,
    input wire logic [7:0] margin_high,
    input wire logic [7:0] fault_suppress
);
    logic page_all;
    wire good_page = cmd.data <= `CPRC_PAGE_LAST || cmd.data == `CPRC_PAGE_ALL;

    // Broadcast reads return junk, so run-byte reads there are not judged
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            page_all <= 1'b0;
        end else if (cmd_wr && cmd.code == `CPRC_CMD_PAGE && good_page) begin
            page_all <= cmd.data == `CPRC_PAGE_ALL;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Command shapes that the properties start from
    sequence s_bad_page;
        cmd_wr && cmd.code == `CPRC_CMD_PAGE && !good_page;
    endsequence
    sequence s_run_read;
        cmd_rd && cmd.code == `CPRC_CMD_OPERATION && !page_all;
    endsequence
    sequence s_known_read;
        cmd_rd && cmd.code inside {8'h00, 8'h01, 8'h02, 8'he4};
    endsequence

    a_read_answers: assert property (s_known_read |=> rd_valid)
        else $error("read not answered");
    a_valid_needs_read: assert property (rd_valid |-> $past(cmd_rd))
        else $error("answer without read");
    a_run_low_zero: assert property (s_run_read |=> rd_data[1:0] == 2'h0)
        else $error("run byte low bits not zero");
    a_bad_page_flag: assert property (s_bad_page |=> cml_fault)
        else $error("reserved selector not flagged");
    a_fault_sticky: assert property (cml_fault && !cml_clear |=> cml_fault)
        else $error("comm fault dropped by itself");
    a_off_cause: assert property (off_now != 8'h00 |->
        $past(cmd_wr) && $past(cmd.code) == `CPRC_CMD_OPERATION)
        else $error("off pulse without run write");
    a_seq_cause: assert property (seq_off != 8'h00 |->
        $past(cmd_wr) && $past(cmd.code) == `CPRC_CMD_OPERATION)
        else $error("sequenced off without run write");
    a_pulse_apart: assert property ((off_now & seq_off) == 8'h00)
        else $error("both off pulses on one channel");
    a_margin_apart: assert property ((margin_low & margin_high) == 8'h00)
        else $error("low and high margin together");
    a_suppress_margin: assert property (
        (fault_suppress & ~(margin_low | margin_high)) == 8'h00)
        else $error("faults suppressed at nominal");
endmodule

bind cprc_page_run cprc_page_run_properties i_props (
    .clk(clk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd(cmd),
    .rd_valid(rd_valid), .rd_data(rd_data), .cml_clear(cml_clear),
    .cml_fault(cml_fault), .channel_run_pin(channel_run_pin),
    .chan_enable(chan_enable), .fast_off(fast_off), .off_now(off_now),
    .seq_off(seq_off), .margin_low(margin_low), .margin_high(margin_high),
    .fault_suppress(fault_suppress)
);

/* tb/cprc_host_model.sv */
`timescale 1ns/100ps

module cprc_host_model (
    input wire logic clk,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output logic cmd_wr,
    output logic cmd_rd,
    output cprc_pkg::cprc_cmd_type cmd,
    output logic cml_clear
);
    // Idle: no strobes, command bytes parked on a pattern, not a stale value
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cml_clear = 1'b0;
        cmd = 16'ha55a;
    end

    // One write or send, strobe held for exactly one rising edge
    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        @(negedge clk);
        cmd_wr = 1'b1;
        cmd = {code, data};
        @(negedge clk);
        cmd_wr = 1'b0;
        cmd = ~cmd;
    endtask

    // One read; the answer stands for the cycle after the taking edge
    task automatic rd(input logic [7:0] code, output logic ok, output logic [7:0] data);
        @(negedge clk);
        cmd_rd = 1'b1;
        cmd = {code, 8'h00};
        @(negedge clk);
        ok = rd_valid;
        data = rd_data;
        cmd_rd = 1'b0;
        cmd = ~cmd;
    endtask

    task automatic clear();
        @(negedge clk);
        cml_clear = 1'b1;
        @(negedge clk);
        cml_clear = 1'b0;
    endtask
endmodule

/* tb/cprc_page_run_bench.sv */
`timescale 1ns/100ps

`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error %s expected %h seen %h", what, exp, got); end end

module cprc_page_run_bench;
    logic clk, rst_b, cmd_wr, cmd_rd, rd_valid, cml_clear, cml_fault;
    cprc_pkg::cprc_cmd_type cmd;
    logic [7:0] rd_data, channel_run_pin, chan_enable, fast_off, off_now, seq_off;
    logic [7:0] margin_low, margin_high, fault_suppress;
    int miscompares = 0;
    int n_tests = 0;

    cprc_page_run i_dut (.clk(clk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd(cmd), .rd_valid(rd_valid), .rd_data(rd_data), .cml_clear(cml_clear),
        .cml_fault(cml_fault), .channel_run_pin(channel_run_pin),
        .chan_enable(chan_enable), .fast_off(fast_off), .off_now(off_now),
        .seq_off(seq_off), .margin_low(margin_low), .margin_high(margin_high),
        .fault_suppress(fault_suppress));
    cprc_host_model i_host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd(cmd), .cml_clear(cml_clear));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Let the edge after a store land, then look
    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] code, input logic [7:0] exp);
        logic ok;
        logic [7:0] got;
        i_host.rd(code, ok, got);
        `CHK("rd_valid", 1'b1, ok)
        `CHK("rd_data", exp, got)
    endtask

    task automatic t_reset_values();
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h02, 8'h1e);
        rd_chk(8'he4, 8'hff);
        `CHK("chan_enable", 8'h00, chan_enable)
    endtask

    task automatic t_run_on();
        channel_run_pin = 8'h01;
        i_host.wr(8'h01, 8'h80);
        repeat (5) step();
        `CHK("chan_enable", 8'h01, chan_enable)
    endtask

    task automatic t_margin();
        i_host.wr(8'h01, 8'h97);
        step();
        `CHK("margin_low", 8'h01, margin_low)
        `CHK("fault_suppress", 8'h01, fault_suppress)
        rd_chk(8'h01, 8'h94);
        i_host.wr(8'h01, 8'ha8);
        step();
        `CHK("margin_high", 8'h01, margin_high)
        `CHK("fault_suppress", 8'h00, fault_suppress)
    endtask

    // Pulses stand for the cycle after the taking edge, so look before step
    task automatic t_off_and_seq();
        i_host.wr(8'h01, 8'h00);
        `CHK("off_now", 8'h01, off_now)
        step();
        `CHK("off_now", 8'h00, off_now)
        `CHK("chan_enable", 8'h00, chan_enable)
        `CHK("margin_high", 8'h00, margin_high)
        i_host.wr(8'h01, 8'h54);
        `CHK("seq_off", 8'h01, seq_off)
        step();
        `CHK("margin_low", 8'h01, margin_low)
        i_host.wr(8'h01, 8'h40);
        `CHK("seq_off", 8'h01, seq_off)
        step();
        `CHK("margin_low", 8'h00, margin_low)
    endtask

    task automatic t_reserved();
        i_host.wr(8'h01, 8'hc0);
        step();
        `CHK("cml_fault", 1'b1, cml_fault)
        rd_chk(8'h01, 8'h40);
        i_host.clear();
        `CHK("cml_fault", 1'b0, cml_fault)
        i_host.wr(8'h00, 8'h08);
        step();
        `CHK("cml_fault", 1'b1, cml_fault)
        rd_chk(8'h00, 8'h00);
        i_host.clear();
    endtask

    task automatic t_bus_off();
        i_host.wr(8'h02, 8'h15);
        rd_chk(8'h02, 8'h17);
        `CHK("fast_off", 8'h01, fast_off)
        i_host.wr(8'h01, 8'h14);
        `CHK("off_now", 8'h00, off_now)
        step();
        `CHK("chan_enable", 8'h01, chan_enable)
        `CHK("margin_low", 8'h01, margin_low)
        `CHK("fault_suppress", 8'h01, fault_suppress)
    endtask

    task automatic t_broadcast();
        logic ok;
        logic [7:0] got;
        i_host.wr(8'he4, 8'h0f);
        i_host.wr(8'h00, 8'hff);
        i_host.wr(8'h01, 8'h94);
        step();
        `CHK("margin_low", 8'h0f, margin_low)
        `CHK("fault_suppress", 8'h0f, fault_suppress)
        i_host.rd(8'h02, ok, got);
        `CHK("rd_valid", 1'b1, ok)
        `CHK("cml_fault", 1'b1, cml_fault)
    endtask

    initial begin
        rst_b = 1'b0;
        channel_run_pin = 8'h00;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        t_reset_values();
        t_run_on();
        t_margin();
        t_off_and_seq();
        t_reserved();
        t_bus_off();
        t_broadcast();
        give_verdict();
    end

    // About 60 cycles are needed; a hang is cut off well beyond that
    initial begin
        #(1000 * 100);
        miscompares++;
        give_verdict();
    end
endmodule
